/* rtl/ipra_defs.vh */
`ifndef IPRA_DEFS_VH
`define IPRA_DEFS_VH

// global space locations (top address bit high, index from the low five bits)
`define IPRA_GLB_PAGE        5'h01
`define IPRA_GLB_IRQ_STATUS  5'h02
`define IPRA_GLB_IRQ_MASK    5'h03
`define IPRA_GLB_CTRL        5'h04
`define IPRA_PAGE_FULL_ADDR  6'h21

// interrupt word layout
`define IPRA_CHAN_LSB        0
`define IPRA_INPUT_LSB       8
`define IPRA_OVR_LSB         12

// control word layout
`define IPRA_CTRL_TRISTATE   0
`define IPRA_CTRL_INTR_CLR   1

// reset values
`define IPRA_PAGE_RST        16'h0000
`define IPRA_MASK_RST        16'hFFFF
`define IPRA_CTRL_RST        2'h0
// idle pin levels in synchroniser order: strobes high, the rest low
`define IPRA_PIN_IDLE        29'h1C00_0000

// page layout inside one channel block of 0x0200
`define IPRA_CHAN_BLOCK_LSB  9
`define IPRA_NUM_CHAN        4'h8
`define IPRA_PROG_LO_BASE    9'h000
`define IPRA_PROG_HI_BASE    9'h040
`define IPRA_COMP_LO_BASE    9'h080
`define IPRA_COMP_HI_BASE    9'h0C0
`define IPRA_CTRL_BASE       9'h100
`define IPRA_CTRL_END        9'h140

// paged region codes
`define IPRA_REG_PROG_LO     3'h0
`define IPRA_REG_PROG_HI     3'h1
`define IPRA_REG_COMP_LO     3'h2
`define IPRA_REG_COMP_HI     3'h3
`define IPRA_REG_CTRL        3'h4
`define IPRA_REG_NONE        3'h7

`endif

/* rtl/ipra_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "ipra_defs.vh"

module ipra_top (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire [15:0] D_IN,
    output reg  [15:0] D_OUT,
    output wire        D_OE,
    input  wire [5:0]  A,
    input  wire        RD_N,
    input  wire        WR_N,
    input  wire        CE_N,
    input  wire [7:0]  CHAN_METER_EVT,
    input  wire [3:0]  INPUT_METER_EVT,
    input  wire [3:0]  OVERFLOW_PIN,
    input  wire        SYNC_SRC,
    output reg         IRQ_OUT,
    output wire        IRQ_OE,
    output reg         SYNC_OUT,
    output wire        SYNC_OUT_OE,
    output reg  [15:0] PAGED_ADDR,
    output reg  [2:0]  PAGED_CHAN,
    output reg  [2:0]  PAGED_REGION,
    output reg  [5:0]  PAGED_TAP,
    output reg  [15:0] PAGED_WDATA,
    output reg         PAGED_WR,
    output reg         PAGED_RD,
    input  wire [15:0] PAGED_RDATA
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// order: ce, rd, wr, address, data, overflow pins
localparam PW = 29;

wire [PW-1:0] pins = {CE_N, RD_N, WR_N, A, D_IN, OVERFLOW_PIN};
reg  [PW-1:0] sync1_r;
reg  [PW-1:0] sync2_r;
reg  [PW-1:0] sync3_r;
reg  [PW-1:0] stable_r;
reg  [PW-1:0] stable_nxt;
integer       i;

// a bit only moves once the second and third stages agree
always @* begin
    stable_nxt = stable_r;
    for (i = 0; i < PW; i = i + 1) begin
        if (sync2_r[i] == sync3_r[i]) begin
            stable_nxt[i] = sync3_r[i];
        end
    end
end

always @(posedge CLK_SYS) begin
    if (RST) begin
        // every stage resets to the idle levels; stages that disagreed with
        // the agreed value would show a false overflow edge after reset
        sync1_r  <= `IPRA_PIN_IDLE;
        sync2_r  <= `IPRA_PIN_IDLE;
        sync3_r  <= `IPRA_PIN_IDLE;
        stable_r <= `IPRA_PIN_IDLE;
    end else begin
        sync1_r  <= pins;
        sync2_r  <= sync1_r;
        sync3_r  <= sync2_r;
        stable_r <= stable_nxt;
    end
end

wire        ce_n_s = stable_r[28];
wire        rd_n_s = stable_r[27];
wire        wr_n_s = stable_r[26];
wire [5:0]  addr_s = stable_r[25:20];
wire [15:0] data_s = stable_r[19:4];
wire [3:0]  ovr_s  = stable_r[3:0];

// ----------------------------------------------------------------
// host strobes
// ----------------------------------------------------------------
// with rd_n tied low (two-pin mode) a write still wins over a read
wire wr_act = !ce_n_s && !wr_n_s;
wire rd_act = !ce_n_s && !rd_n_s && wr_n_s;

reg         wr_prev_r;
reg         rd_prev_r;
reg  [5:0]  wr_addr_r;
reg  [15:0] wr_data_r;

// commit at the end of the strobe, so data has settled for the whole access
wire wr_done  = wr_prev_r && !wr_act;
wire rd_start = rd_act && !rd_prev_r;

always @(posedge CLK_SYS) begin
    if (RST) begin
        wr_prev_r <= 1'b0;
        rd_prev_r <= 1'b0;
        wr_addr_r <= 6'h00;
        wr_data_r <= 16'h0000;
    end else begin
        wr_prev_r <= wr_act;
        rd_prev_r <= rd_act;
        if (wr_act) begin
            wr_addr_r <= addr_s;
            wr_data_r <= data_s;
        end
    end
end

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
reg [15:0] page_r;

function [15:0] paged_sum;
    input [15:0] page;
    input [4:0]  low;
    begin
        paged_sum = page + {11'h000, low};
    end
endfunction

function [2:0] region_of;
    input [15:0] pa;
    reg   [8:0]  off;
    begin
        off = pa[8:0];
        if (pa[15:12] != 4'h0) begin
            region_of = `IPRA_REG_NONE;
        end else if (off >= `IPRA_CTRL_END) begin
            region_of = `IPRA_REG_NONE;
        end else if (off >= `IPRA_CTRL_BASE) begin
            region_of = `IPRA_REG_CTRL;
        end else if (off >= `IPRA_COMP_HI_BASE) begin
            region_of = `IPRA_REG_COMP_HI;
        end else if (off >= `IPRA_COMP_LO_BASE) begin
            region_of = `IPRA_REG_COMP_LO;
        end else if (off >= `IPRA_PROG_HI_BASE) begin
            region_of = `IPRA_REG_PROG_HI;
        end else begin
            region_of = `IPRA_REG_PROG_LO;
        end
    end
endfunction

// global space when the top bit is high
function is_global;
    input [5:0] a;
    begin
        is_global = a[5];
    end
endfunction

// paged access uses the live page register
wire [15:0] rd_paddr   = paged_sum(page_r, addr_s[4:0]);
wire [15:0] wr_paddr   = paged_sum(page_r, wr_addr_r[4:0]);
wire [2:0]  rd_region  = region_of(rd_paddr);
wire [2:0]  wr_region  = region_of(wr_paddr);
wire        wr_global  = wr_done && is_global(wr_addr_r);
wire        wr_paged   = wr_done && !is_global(wr_addr_r);

// ----------------------------------------------------------------
// global registers
// ----------------------------------------------------------------
reg  [15:0] status_r;
reg  [15:0] status_nxt;
reg  [15:0] mask_r;
reg  [1:0]  ctrl_r;
reg  [3:0]  ovr_prev_r;

// sixteen sources, overflow taken on a pin's rising edge
wire [15:0] events = {ovr_s & ~ovr_prev_r, INPUT_METER_EVT, CHAN_METER_EVT};
wire        intr_clr = ctrl_r[`IPRA_CTRL_INTR_CLR];
wire        tristate = ctrl_r[`IPRA_CTRL_TRISTATE];

always @(posedge CLK_SYS) begin
    if (RST) begin
        page_r <= `IPRA_PAGE_RST;
        mask_r <= `IPRA_MASK_RST;
        ctrl_r <= `IPRA_CTRL_RST;
    end else if (wr_global) begin
        case (wr_addr_r[4:0])
            // page register at full address 0x21
            `IPRA_GLB_PAGE: begin
                page_r <= wr_data_r;
            end
            `IPRA_GLB_IRQ_MASK: begin
                mask_r <= wr_data_r;
            end
            `IPRA_GLB_CTRL: begin
                ctrl_r <= wr_data_r[1:0];
            end
            default: begin
            end
        endcase
    end
end

// any status write clears; a new event in that cycle still sets
always @* begin
    status_nxt = status_r;
    if (wr_global && wr_addr_r[4:0] == `IPRA_GLB_IRQ_STATUS) begin
        status_nxt = 16'h0000;
    end
    status_nxt = status_nxt | events;
    // debug clear holds every bit clear
    if (intr_clr) begin
        status_nxt = 16'h0000;
    end
end

always @(posedge CLK_SYS) begin
    if (RST) begin
        status_r   <= 16'h0000;
        ovr_prev_r <= 4'h0;
        IRQ_OUT    <= 1'b0;
        SYNC_OUT   <= 1'b0;
    end else begin
        status_r   <= status_nxt;
        ovr_prev_r <= ovr_s;
        IRQ_OUT    <= |(status_nxt & ~mask_r);
        SYNC_OUT   <= SYNC_SRC;
    end
end

assign IRQ_OE      = !tristate;
assign SYNC_OUT_OE = !tristate;

// ----------------------------------------------------------------
// read path
// ----------------------------------------------------------------
reg [15:0] rd_mux;

// status is readable for the host
always @* begin
    rd_mux = 16'h0000;
    if (is_global(addr_s)) begin
        case (addr_s[4:0])
            `IPRA_GLB_PAGE:       rd_mux = page_r;
            `IPRA_GLB_IRQ_STATUS: rd_mux = status_r;
            `IPRA_GLB_IRQ_MASK:   rd_mux = mask_r;
            `IPRA_GLB_CTRL:       rd_mux = {14'h0000, ctrl_r};
            default:              rd_mux = 16'h0000;
        endcase
    end else if (rd_region != `IPRA_REG_NONE) begin
        rd_mux = PAGED_RDATA;
    end
end

// data lines driven only during a read
assign D_OE = rd_act;

always @(posedge CLK_SYS) begin
    if (RST) begin
        D_OUT <= 16'h0000;
    end else if (rd_act) begin
        D_OUT <= rd_mux;
    end
end

// ----------------------------------------------------------------
// paged space port
// ----------------------------------------------------------------
reg [15:0] pa_nxt;
reg [2:0]  rg_nxt;

always @* begin
    pa_nxt = wr_paged ? wr_paddr : rd_paddr;
    rg_nxt = wr_paged ? wr_region : rd_region;
end

always @(posedge CLK_SYS) begin
    if (RST) begin
        PAGED_ADDR   <= 16'h0000;
        PAGED_CHAN   <= 3'h0;
        PAGED_REGION <= `IPRA_REG_NONE;
        PAGED_TAP    <= 6'h00;
        PAGED_WDATA  <= 16'h0000;
        PAGED_WR     <= 1'b0;
        PAGED_RD     <= 1'b0;
    end else begin
        // channel number from the block field
        PAGED_ADDR   <= pa_nxt;
        PAGED_CHAN   <= pa_nxt[11:`IPRA_CHAN_BLOCK_LSB];
        PAGED_REGION <= rg_nxt;
        PAGED_TAP    <= pa_nxt[5:0];
        PAGED_WDATA  <= wr_data_r;
        PAGED_WR     <= wr_paged && wr_region != `IPRA_REG_NONE;
        PAGED_RD     <= rd_start && !is_global(addr_s) && rd_region != `IPRA_REG_NONE;
    end
end

endmodule
`default_nettype wire

/* sim/ipra_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ipra_props (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        SYNC_SRC,
    input wire logic        IRQ_OUT,
    input wire logic        IRQ_OE,
    input wire logic        SYNC_OUT,
    input wire logic        SYNC_OUT_OE,
    input wire logic        D_OE,
    input wire logic [15:0] PAGED_ADDR,
    input wire logic [2:0]  PAGED_CHAN,
    input wire logic [2:0]  PAGED_REGION,
    input wire logic [5:0]  PAGED_TAP,
    input wire logic        PAGED_WR,
    input wire logic        PAGED_RD
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // offset bits 8:6 equal the region code inside a mapped channel block
    function automatic logic [2:0] region_of(input logic [15:0] ad);
        return (ad[15:12] != 4'h0 || ad[8:6] > 3'h4) ? 3'h7 : ad[8:6];
    endfunction
    chk_oe_pair: assert property (IRQ_OE == SYNC_OUT_OE)
        else $error("interrupt and sync enables differ");
    chk_wr_pulse: assert property (PAGED_WR |=> !PAGED_WR)
        else $error("paged write strobe longer than one cycle");
    chk_rd_pulse: assert property (PAGED_RD |=> !PAGED_RD)
        else $error("paged read strobe longer than one cycle");
    chk_tap_field: assert property (PAGED_TAP == PAGED_ADDR[5:0])
        else $error("tap index not taken from paged address");
    chk_chan_field: assert property (PAGED_CHAN == PAGED_ADDR[11:9])
        else $error("channel not taken from paged address");
    chk_region_code: assert property (PAGED_WR |-> PAGED_REGION == region_of(PAGED_ADDR))
        else $error("region code wrong for paged address");
    chk_strobe_mapped: assert property (PAGED_WR |-> PAGED_REGION != 3'h7)
        else $error("paged write strobed on unmapped address");
    chk_rst_quiet: assert property ($fell(RST) |-> !IRQ_OUT && !PAGED_WR && !D_OE && IRQ_OE)
        else $error("outputs not idle after reset");
    chk_sync_follow: assert property (!$past(RST) |-> SYNC_OUT == $past(SYNC_SRC))
        else $error("sync output does not follow its source");
    cov_paged_wr: cover property (PAGED_WR);
    cov_paged_rd: cover property (PAGED_RD);
    cov_irq_rise: cover property ($rose(IRQ_OUT));
endmodule
bind ipra_top ipra_props u_props (.CLK_SYS(CLK_SYS), .RST(RST), .SYNC_SRC(SYNC_SRC),
    .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE), .SYNC_OUT(SYNC_OUT), .SYNC_OUT_OE(SYNC_OUT_OE),
    .D_OE(D_OE), .PAGED_ADDR(PAGED_ADDR), .PAGED_CHAN(PAGED_CHAN),
    .PAGED_REGION(PAGED_REGION), .PAGED_TAP(PAGED_TAP), .PAGED_WR(PAGED_WR),
    .PAGED_RD(PAGED_RD));
`default_nettype wire

/* sim/ipra_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ipra_host (
    input wire logic        clk,
    input wire logic [15:0] d_out,
    input wire logic        d_oe,
    output var logic [15:0] d_in,
    output var logic [5:0]  a,
    output var logic        rd_n,
    output var logic        wr_n,
    output var logic        ce_n
);
    // two-pin mode: read strobe held low, a write strobe still wins
    logic tie_rd = 1'b0;
    initial begin
        d_in = 16'h0000;
        a = 6'h00;
        {rd_n, wr_n, ce_n} = 3'b111;
    end
    // memory-like cycle
    // strobes are held well past the four-stage pin synchroniser
    task automatic access(input logic [5:0] ad, input logic [15:0] wd, input logic wr,
                          output logic [15:0] rv);
        ce_n <= 1'b0;
        rd_n <= wr && !tie_rd;
        wr_n <= !wr;
        a <= ad;
        d_in <= wd;
        repeat (9) @(posedge clk);
        // an undriven bus reads as the inverse, so a missed read cannot pass
        rv = d_oe ? d_out : ~d_out;
        {rd_n, wr_n, ce_n} <= {!tie_rd, 2'b11};
        // released lines show the inverse so stale data never looks valid
        d_in <= ~wd;
        a <= ~ad;
        repeat (7) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/ipra_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ipra_top_bench;
    logic        CLK_SYS = 1'b0;
    logic        RST = 1'b1;
    logic        SYNC_SRC = 1'b0;
    logic [7:0]  CHAN_METER_EVT = 8'h00;
    logic [3:0]  INPUT_METER_EVT = 4'h0;
    logic [3:0]  OVERFLOW_PIN = 4'h0;
    logic [15:0] PAGED_RDATA = 16'h0000;
    logic [15:0] D_IN, D_OUT, PAGED_ADDR, PAGED_WDATA, cap_addr, cap_data, v;
    logic [5:0]  A, PAGED_TAP;
    logic [2:0]  PAGED_CHAN, PAGED_REGION, cap_reg, cap_chan;
    logic [15:0] n_prd = 16'h0000;
    logic        RD_N, WR_N, CE_N, D_OE, IRQ_OUT, IRQ_OE, SYNC_OUT, SYNC_OUT_OE;
    logic        PAGED_WR, PAGED_RD;
    logic [15:0] pg [7] = '{16'h0000, 16'h0040, 16'h0080, 16'h00C0, 16'h0120, 16'h0300, 16'h0440};
    logic [2:0]  rg [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h1};
    logic [2:0]  ch [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2};
    int          n_errors = 0;
    int          compares = 0;
    ipra_top u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE),
        .A(A), .RD_N(RD_N), .WR_N(WR_N), .CE_N(CE_N), .CHAN_METER_EVT(CHAN_METER_EVT),
        .INPUT_METER_EVT(INPUT_METER_EVT), .OVERFLOW_PIN(OVERFLOW_PIN), .SYNC_SRC(SYNC_SRC),
        .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE), .SYNC_OUT(SYNC_OUT), .SYNC_OUT_OE(SYNC_OUT_OE),
        .PAGED_ADDR(PAGED_ADDR), .PAGED_CHAN(PAGED_CHAN), .PAGED_REGION(PAGED_REGION),
        .PAGED_TAP(PAGED_TAP), .PAGED_WDATA(PAGED_WDATA), .PAGED_WR(PAGED_WR),
        .PAGED_RD(PAGED_RD), .PAGED_RDATA(PAGED_RDATA));
    ipra_host u_host (.clk(CLK_SYS), .d_out(D_OUT), .d_oe(D_OE), .d_in(D_IN), .a(A),
        .rd_n(RD_N), .wr_n(WR_N), .ce_n(CE_N));
    always #50 CLK_SYS = ~CLK_SYS;
    // ----
    // paged space stand-in and write capture
    // ----
    always @(posedge CLK_SYS) begin
        SYNC_SRC <= ~SYNC_SRC;
        PAGED_RDATA <= PAGED_ADDR ^ 16'h5A5A;
        if (PAGED_WR) begin
            cap_addr <= PAGED_ADDR;
            cap_data <= PAGED_WDATA;
            cap_reg <= PAGED_REGION;
            cap_chan <= PAGED_CHAN;
        end
        if (PAGED_RD) begin
            n_prd <= n_prd + 16'h0001;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] ad, input logic [15:0] wd);
        u_host.access(ad, wd, 1'b1, v);
    endtask
    task automatic rd(input logic [5:0] ad, input logic [15:0] exp);
        u_host.access(ad, 16'h0000, 1'b0, v);
        chk(v, exp);
    endtask
    task automatic evt(input logic [7:0] c, input logic [3:0] m);
        CHAN_METER_EVT <= c;
        INPUT_METER_EVT <= m;
        @(posedge CLK_SYS);
        CHAN_METER_EVT <= 8'h00;
        INPUT_METER_EVT <= 4'h0;
        repeat (3) @(posedge CLK_SYS);
    endtask
    task automatic close_out;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        rd(6'h23, 16'hFFFF);
        rd(6'h22, 16'h0000);
        rd(6'h3F, 16'h0000);
        for (int k = 0; k < 7; k++) begin
            wr(6'h21, pg[k]);
            rd(6'h21, pg[k]);
            wr(6'h03, 16'hC0DE ^ pg[k]);
            chk(cap_addr, pg[k] + 16'h0003);
            chk({13'h0000, cap_reg}, {13'h0000, rg[k]});
            chk(cap_data, 16'hC0DE ^ pg[k]);
            chk({13'h0000, cap_chan}, {13'h0000, ch[k]});
            rd(6'h07, (pg[k] + 16'h0007) ^ 16'h5A5A);
        end
        chk(n_prd, 16'h0007);
        u_host.tie_rd = 1'b1;
        wr(6'h21, 16'h0120);
        rd(6'h21, 16'h0120);
        u_host.tie_rd = 1'b0;
        wr(6'h21, 16'h1000);
        rd(6'h02, 16'h0000);
        wr(6'h05, 16'hBEEF);
        chk(cap_addr, 16'h0443);
        wr(6'h23, 16'hFFFE);
        evt(8'h01, 4'h2);
        chk({15'h0000, IRQ_OUT}, 16'h0001);
        rd(6'h22, 16'h0201);
        wr(6'h22, 16'h0000);
        chk({15'h0000, IRQ_OUT}, 16'h0000);
        evt(8'h80, 4'h0);
        OVERFLOW_PIN <= 4'h8;
        repeat (8) @(posedge CLK_SYS);
        chk({15'h0000, IRQ_OUT}, 16'h0000);
        rd(6'h22, 16'h8080);
        wr(6'h22, 16'h0000);
        wr(6'h24, 16'h0002);
        evt(8'h01, 4'h0);
        chk({15'h0000, IRQ_OUT}, 16'h0000);
        rd(6'h22, 16'h0000);
        wr(6'h24, 16'h0001);
        chk({14'h0000, IRQ_OE, SYNC_OUT_OE}, 16'h0000);
        wr(6'h24, 16'h0000);
        chk({14'h0000, IRQ_OE, SYNC_OUT_OE}, 16'h0003);
        close_out;
    end
endmodule
`default_nettype wire
